// File: design/apbi_pkg.sv
// shared constants and types for the accelerator and port bus
`default_nettype none

package apbi_pkg;

    localparam int DATA_W     = 32;
    localparam int IB_W       = 8;
    localparam int CMD_W      = 8;
    localparam int CSR_W      = 18;
    localparam int CMD_LSB    = 10;
    localparam int OP_W       = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int ENTRY_W    = OP_W + CMD_W + DATA_W;
    localparam int ENT_OP_LSB = CMD_W + DATA_W;
    localparam int ENT_CMD_LSB = DATA_W;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
    localparam logic [CMD_W-1:0]  CMD_RST  = 8'h00;
    localparam logic [IB_W-1:0]   IB_RST   = 8'h00;

    typedef enum logic [3:0] {
        APBI_OP_DECODE     = 4'h0,
        APBI_OP_OPERAND    = 4'h1,
        APBI_OP_POLYNOMIAL_INSTRUCTION       = 4'h2,
        APBI_OP_RESULT     = 4'h3,
        APBI_OP_TRAP       = 4'h4,
        APBI_OP_READ_UPC   = 4'h5,
        APBI_OP_PORT_CMD   = 4'h6,
        APBI_OP_PORT_WRITE = 4'h7,
        APBI_OP_PORT_READ  = 4'h8
    } apbi_op_t;

    typedef enum logic [2:0] {
        APBI_S_IDLE      = 3'h0,
        APBI_S_POLYNOMIAL_INSTRUCTION_WAIT = 3'h1,
        APBI_S_RESULT    = 3'h2,
        APBI_S_PORT_WAIT = 3'h3,
        APBI_S_HOLD      = 3'h4,
        APBI_S_CAPTURE   = 3'h5
    } apbi_state_t;

endpackage : apbi_pkg

`default_nettype wire

// File: design/apbi_bus_if.sv
// accelerator and port bus between the processor end and the far end
`timescale 1ns/1ns
`default_nettype none

interface apbi_bus_if
    import apbi_pkg::*;
(
    input wire logic clk
);
    logic [DATA_W-1:0] cpu_data_out;
    logic              cpu_data_oe;
    logic [DATA_W-1:0] far_data_out;
    logic              far_data_oe;
    logic [DATA_W-1:0] data_bus;
    logic [IB_W-1:0]   instruction_byte_bus;
    logic              decode_state_flag_n;
    logic              operand_valid_n;
    logic              accel_sync;
    logic              accel_select;
    logic              result_read_ready_n;
    logic              accel_trap_n;
    logic              fetch_accel_micro_pc_n;
    logic [CMD_W-1:0]  port_command_byte;
    logic              port_command_valid;
    logic              port_transfer_request_n;
    logic              port_transfer_grant_n;

    // wire level of the shared data lines, pulled low when idle
    assign data_bus = cpu_data_oe ? cpu_data_out :
                      (far_data_oe ? far_data_out : DATA_RST);

    modport cpu_end (
        input  data_bus, accel_sync, port_transfer_request_n,
        output cpu_data_out, cpu_data_oe, instruction_byte_bus,
        output decode_state_flag_n, operand_valid_n, accel_select,
        output result_read_ready_n, accel_trap_n, fetch_accel_micro_pc_n,
        output port_command_byte, port_command_valid, port_transfer_grant_n
    );

    modport far_end (
        input  data_bus, instruction_byte_bus, decode_state_flag_n,
        input  operand_valid_n, accel_select, result_read_ready_n,
        input  accel_trap_n, fetch_accel_micro_pc_n, port_command_byte,
        input  port_command_valid, port_transfer_grant_n,
        output far_data_out, far_data_oe, accel_sync, port_transfer_request_n
    );
endinterface : apbi_bus_if

`default_nettype wire

// File: design/apbi_cpu_end.sv
// processor end of the accelerator and port bus, with its command fifo
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// processor end
module apbi_cpu_end
    import apbi_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               srst,
    apbi_bus_if.cpu_end             bus,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire logic [OP_W-1:0]    cmd_op,
    input  wire logic [CSR_W-1:0]   cmd_csr,
    input  wire logic [DATA_W-1:0]  cmd_data,
    output logic                    rsp_valid,
    output logic [DATA_W-1:0]       rsp_data,
    output logic                    busy
);
    typedef struct packed {
        apbi_state_t       state;
        logic [ENTRY_W-1:0] cur;
        logic              dec_n;
        logic              opv_n;
        logic              sel;
        logic              rrr_n;
        logic              trap_n;
        logic              fetch_n;
        logic [CMD_W-1:0]  cmd_byte;
        logic              cmd_vld;
        logic              grant_n;
        logic [DATA_W-1:0] d_out;
        logic              d_oe;
        logic [IB_W-1:0]   ib;
        logic              rsp_v;
        logic [DATA_W-1:0] rsp_d;
        logic              busy;
        logic              ready;
    } apbi_cpu_st_t;

    apbi_cpu_st_t       r;
    apbi_cpu_st_t       n;
    logic               f_in_ready;
    logic               f_valid;
    logic               f_pop;
    logic [ENTRY_W-1:0] f_data;
    logic [ENTRY_W-1:0] f_in;
    apbi_op_t           op;
    logic [DATA_W-1:0]  word;
    logic [CMD_W-1:0]   cbyte;

    assign f_in  = {cmd_op, cmd_csr[CMD_LSB +: CMD_W], cmd_data};
    assign f_pop = (r.state == APBI_S_IDLE);

    apbi_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (cmd_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    always_comb begin
        n         = r;
        n.dec_n   = 1'b1;
        n.opv_n   = 1'b1;
        n.sel     = 1'b0;
        n.rrr_n   = 1'b1;
        n.trap_n  = 1'b1;
        n.fetch_n = 1'b1;
        n.cmd_vld = 1'b0;
        n.grant_n = 1'b1;
        n.d_oe    = 1'b0;
        n.rsp_v   = 1'b0;
        op    = apbi_op_t'(r.cur[ENT_OP_LSB +: OP_W]);
        word  = r.cur[DATA_W-1:0];
        cbyte = r.cur[ENT_CMD_LSB +: CMD_W];
        case (r.state)
            APBI_S_IDLE: begin
                if (f_valid) begin
                    n.cur = f_data;
                    op    = apbi_op_t'(f_data[ENT_OP_LSB +: OP_W]);
                    word  = f_data[DATA_W-1:0];
                    cbyte = f_data[ENT_CMD_LSB +: CMD_W];
                    case (op)
                        APBI_OP_DECODE: begin
                            n.dec_n = 1'b0;
                            n.ib    = word[IB_W-1:0];
                        end
                        APBI_OP_OPERAND: begin
                            n.d_out = word;
                            n.d_oe  = 1'b1;
                            n.opv_n = 1'b0;
                        end
                        APBI_OP_POLYNOMIAL_INSTRUCTION: begin
                            n.state = APBI_S_POLYNOMIAL_INSTRUCTION_WAIT;
                        end
                        APBI_OP_RESULT: begin
                            n.sel   = 1'b1;
                            n.rrr_n = 1'b0;
                            n.state = APBI_S_RESULT;
                        end
                        APBI_OP_TRAP: begin
                            n.d_out  = word;
                            n.d_oe   = 1'b1;
                            n.trap_n = 1'b0;
                        end
                        APBI_OP_READ_UPC: begin
                            n.fetch_n = 1'b0;
                            n.state   = APBI_S_HOLD;
                        end
                        APBI_OP_PORT_CMD: begin
                            n.cmd_byte = cbyte;
                            n.cmd_vld  = 1'b1;
                            n.d_out    = word;
                            n.d_oe     = 1'b1;
                        end
                        APBI_OP_PORT_WRITE,
                        APBI_OP_PORT_READ: begin
                            n.state = APBI_S_PORT_WAIT;
                        end
                        default: begin
                            n.state = APBI_S_IDLE;
                        end
                    endcase
                end
            end
            APBI_S_POLYNOMIAL_INSTRUCTION_WAIT: begin
                if (bus.accel_sync) begin
                    n.d_out = word;
                    n.d_oe  = 1'b1;
                    n.opv_n = 1'b0;
                    n.state = APBI_S_IDLE;
                end
            end
            APBI_S_RESULT: begin
                if (bus.accel_sync) begin
                    n.rsp_v = 1'b1;
                    n.rsp_d = bus.data_bus;
                    n.state = APBI_S_IDLE;
                end else begin
                    n.sel   = 1'b1;
                    n.rrr_n = 1'b0;
                end
            end
            APBI_S_PORT_WAIT: begin
                if (!bus.port_transfer_request_n) begin
                    n.grant_n  = 1'b0;
                    n.cmd_byte = cbyte;
                    n.cmd_vld  = 1'b1;
                    if (op == APBI_OP_PORT_READ) begin
                        n.rrr_n = 1'b0;
                        n.state = APBI_S_HOLD;
                    end else begin
                        n.d_out = word;
                        n.d_oe  = 1'b1;
                        n.state = APBI_S_IDLE;
                    end
                end
            end
            APBI_S_HOLD: begin
                n.rrr_n = 1'b0;
                n.sel   = (op == APBI_OP_READ_UPC);
                n.state = APBI_S_CAPTURE;
            end
            APBI_S_CAPTURE: begin
                n.rsp_v = 1'b1;
                n.rsp_d = bus.data_bus;
                n.state = APBI_S_IDLE;
            end
            default: begin
                n.state = APBI_S_IDLE;
            end
        endcase
        if (!n.rrr_n) begin
            n.d_oe = 1'b0;
        end
        n.busy  = (n.state != APBI_S_IDLE) || f_valid;
        n.ready = f_in_ready;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r          <= '0;
            r.state    <= APBI_S_IDLE;
            r.dec_n    <= 1'b1;
            r.opv_n    <= 1'b1;
            r.rrr_n    <= 1'b1;
            r.trap_n   <= 1'b1;
            r.fetch_n  <= 1'b1;
            r.grant_n  <= 1'b1;
            r.cmd_byte <= CMD_RST;
            r.d_out    <= DATA_RST;
            r.ib       <= IB_RST;
        end else begin
            r <= n;
        end
    end

    assign bus.cpu_data_out           = r.d_out;
    assign bus.cpu_data_oe            = r.d_oe;
    assign bus.instruction_byte_bus   = r.ib;
    assign bus.decode_state_flag_n    = r.dec_n;
    assign bus.operand_valid_n        = r.opv_n;
    assign bus.accel_select           = r.sel;
    assign bus.result_read_ready_n    = r.rrr_n;
    assign bus.accel_trap_n           = r.trap_n;
    assign bus.fetch_accel_micro_pc_n = r.fetch_n;
    assign bus.port_command_byte      = r.cmd_byte;
    assign bus.port_command_valid     = r.cmd_vld;
    assign bus.port_transfer_grant_n  = r.grant_n;
    assign cmd_ready                  = r.ready;
    assign rsp_valid                  = r.rsp_v;
    assign rsp_data                   = r.rsp_d;
    assign busy                       = r.busy;
endmodule : apbi_cpu_end

`default_nettype wire

// File: design/apbi_far_end.sv
// far end of the bus (accelerator, port device) and the command fifo
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// parameterised fifo
module apbi_fifo #(
    parameter int WIDTH = 44,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               cnt;
        logic                        full;
        logic                        empty;
    } apbi_fifo_st_t;

    apbi_fifo_st_t r;
    apbi_fifo_st_t n;
    logic          push;
    logic          pop;

    assign in_ready  = ~r.full;
    assign out_valid = ~r.empty;
    assign out_data  = r.mem[r.rd];

    always_comb begin
        n    = r;
        push = in_valid & ~r.full;
        pop  = out_ready & ~r.empty;
        if (push) begin
            n.mem[r.wr] = in_data;
            n.wr = (r.wr == PW'(DEPTH - 1)) ? '0 : r.wr + PW'(1);
        end
        if (pop) begin
            n.rd = (r.rd == PW'(DEPTH - 1)) ? '0 : r.rd + PW'(1);
        end
        n.cnt   = r.cnt + CW'(push) - CW'(pop);
        n.full  = (n.cnt == CW'(DEPTH));
        n.empty = (n.cnt == '0);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r       <= '0;
            r.empty <= 1'b1;
        end else begin
            r <= n;
        end
    end
endmodule : apbi_fifo

////////////////////////////////////////////////////////////////////////////
// far end
module apbi_far_end
    import apbi_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    apbi_bus_if.far_end            bus,
    output logic                   opcode_valid,
    output logic [IB_W-1:0]        opcode_byte,
    output logic                   operand_strobe,
    output logic [DATA_W-1:0]      operand_word,
    input  wire logic              result_load,
    input  wire logic [DATA_W-1:0] result_word,
    output logic                   result_pending,
    input  wire logic              polynomial_instruction_ready,
    output logic [DATA_W-1:0]      micro_pc,
    output logic                   trap_strobe,
    input  wire logic              port_ready,
    input  wire logic [DATA_W-1:0] port_read_word,
    output logic                   port_cmd_strobe,
    output logic [CMD_W-1:0]       port_cmd_byte,
    output logic                   port_write_strobe,
    output logic [DATA_W-1:0]      port_write_word
);
    typedef struct packed {
        logic              res_full;
        logic [DATA_W-1:0] res_word;
        logic              sync;
        logic              armed;
        logic [DATA_W-1:0] d_out;
        logic              d_oe;
        logic [DATA_W-1:0] upc;
        logic              trap_v;
        logic              req_n;
        logic              ib_v;
        logic [IB_W-1:0]   ib;
        logic              opnd_v;
        logic [DATA_W-1:0] opnd;
        logic              pcmd_v;
        logic [CMD_W-1:0]  pcmd;
        logic              pwr_v;
        logic [DATA_W-1:0] pwr;
    } apbi_far_st_t;

    apbi_far_st_t r;
    apbi_far_st_t n;
    logic         reading;

    always_comb begin
        n        = r;
        n.sync   = 1'b0;
        n.d_oe   = 1'b0;
        n.trap_v = 1'b0;
        n.ib_v   = 1'b0;
        n.opnd_v = 1'b0;
        n.pcmd_v = 1'b0;
        n.pwr_v  = 1'b0;
        reading  = !bus.result_read_ready_n;
        if (r.res_full && bus.accel_select && reading && !r.sync) begin
            n.d_out    = r.res_word;
            n.d_oe     = 1'b1;
            n.sync     = 1'b1;
            n.res_full = 1'b0;
        end else if (polynomial_instruction_ready && !r.armed && !reading) begin
            n.sync  = 1'b1;
            n.armed = 1'b1;
        end
        if (result_load) begin
            n.res_full = 1'b1;
            n.res_word = result_word;
        end
        if (!bus.operand_valid_n) begin
            n.opnd_v = 1'b1;
            n.opnd   = bus.data_bus;
            n.armed  = n.armed && !r.armed;
        end
        if (!bus.decode_state_flag_n) begin
            n.ib_v = 1'b1;
            n.ib   = bus.instruction_byte_bus;
        end
        if (!bus.accel_trap_n) begin
            n.upc    = bus.data_bus;
            n.trap_v = 1'b1;
        end
        if (!bus.fetch_accel_micro_pc_n) begin
            n.d_out = r.upc;
            n.d_oe  = 1'b1;
        end
        if (port_ready && r.req_n && bus.port_transfer_grant_n) begin
            n.req_n = 1'b0;
        end
        if (bus.port_command_valid) begin
            n.pcmd_v = 1'b1;
            n.pcmd   = bus.port_command_byte;
        end
        if (!bus.port_transfer_grant_n) begin
            n.req_n = 1'b1;
            if (reading) begin
                n.d_out = port_read_word;
                n.d_oe  = 1'b1;
            end else begin
                n.pwr_v = 1'b1;
                n.pwr   = bus.data_bus;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r       <= '0;
            r.req_n <= 1'b1;
            r.upc   <= DATA_RST;
        end else begin
            r <= n;
        end
    end

    assign bus.far_data_out            = r.d_out;
    assign bus.far_data_oe             = r.d_oe;
    assign bus.accel_sync              = r.sync;
    assign bus.port_transfer_request_n = r.req_n;
    assign opcode_valid                = r.ib_v;
    assign opcode_byte                 = r.ib;
    assign operand_strobe              = r.opnd_v;
    assign operand_word                = r.opnd;
    assign result_pending              = r.res_full;
    assign micro_pc                    = r.upc;
    assign trap_strobe                 = r.trap_v;
    assign port_cmd_strobe             = r.pcmd_v;
    assign port_cmd_byte               = r.pcmd;
    assign port_write_strobe           = r.pwr_v;
    assign port_write_word             = r.pwr;
endmodule : apbi_far_end

`default_nettype wire

// File: verif/apbi_props.sv
// assertions on the accelerator and port bus wires
`timescale 1ns/1ns
`default_nettype none

module apbi_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic cpu_data_oe,
    input wire logic far_data_oe,
    input wire logic operand_valid_n,
    input wire logic accel_sync,
    input wire logic accel_select,
    input wire logic result_read_ready_n,
    input wire logic accel_trap_n,
    input wire logic fetch_accel_micro_pc_n,
    input wire logic port_command_valid,
    input wire logic port_transfer_request_n,
    input wire logic port_transfer_grant_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////
    // multi-step sequences
    sequence s_upc_read;
        !fetch_accel_micro_pc_n ##1 (!result_read_ready_n && !cpu_data_oe);
    endsequence
    sequence s_grant_clear;
        (port_command_valid && !port_transfer_request_n)
            ##1 port_transfer_request_n;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // properties
    property p_read_release;
        !result_read_ready_n |-> !cpu_data_oe;
    endproperty
    property p_operand_drive;
        !operand_valid_n |-> cpu_data_oe && result_read_ready_n;
    endproperty
    property p_trap_drive;
        !accel_trap_n |-> cpu_data_oe;
    endproperty
    property p_upc_read;
        !fetch_accel_micro_pc_n |-> s_upc_read;
    endproperty
    property p_grant_after_req;
        !port_transfer_grant_n |-> !$past(port_transfer_request_n);
    endproperty
    property p_grant_clear;
        !port_transfer_grant_n |-> s_grant_clear;
    endproperty
    property p_result_sync;
        accel_sync && accel_select && !result_read_ready_n |-> far_data_oe;
    endproperty
    property p_select_ready;
        $rose(accel_select) |-> !result_read_ready_n;
    endproperty
    property p_far_drive;
        far_data_oe |-> !result_read_ready_n;
    endproperty

    a_read_release: assert property (p_read_release)
        else $error("cpu drives data while reading");
    a_operand_drive: assert property (p_operand_drive)
        else $error("operand valid without cpu drive");
    a_trap_drive: assert property (p_trap_drive)
        else $error("trap without micro-address driven");
    a_upc_read: assert property (p_upc_read)
        else $error("micro-pc fetch not followed by read ready");
    a_grant_after_req: assert property (p_grant_after_req)
        else $error("grant without pending request");
    a_grant_clear: assert property (p_grant_clear)
        else $error("request not cleared after grant");
    a_result_sync: assert property (p_result_sync)
        else $error("result sync without far drive");
    a_select_ready: assert property (p_select_ready)
        else $error("select raised without read ready");
    a_far_drive: assert property (p_far_drive)
        else $error("far end drives while cpu not reading");
endmodule : apbi_props

`default_nettype wire

// File: verif/accelerator_port_bus_interface_tb.sv
// self-checking bench joining the processor end to the far end
`timescale 1ns/1ns
`default_nettype none

module accelerator_port_bus_interface_tb
    import apbi_pkg::*;
;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic              cmd_valid = 1'b0;
    logic [OP_W-1:0]   cmd_op = 4'h0;
    logic [CSR_W-1:0]  cmd_csr = 18'h00000;
    logic [DATA_W-1:0] cmd_data = 32'h00000000;
    logic              result_load = 1'b0;
    logic [DATA_W-1:0] result_word = 32'h00000000;
    logic              polynomial_instruction_ready = 1'b0;
    logic              port_ready = 1'b0;
    logic [DATA_W-1:0] rd_word = 32'h00000000;
    logic              cmd_ready, rsp_valid, busy, opc_v, op_s, trap_s;
    logic              pc_s, pw_s, pend;
    logic [DATA_W-1:0] rsp_data, op_w, upc, pw_w;
    logic [7:0]        opc_b, pc_b;
    logic [31:0]       opc_q, ib_q, op_q, bus_q, pc_q, wr_q;
    int                op_n = 0;
    int                rsp_n = 0;
    int                trap_cnt = 0;
    int                fail_count = 0;
    int                checked = 0;
    int                n;

    always #4 clk = ~clk;

    apbi_bus_if i_apbi_bus_if (.clk(clk));
    apbi_cpu_end i_apbi_cpu_end (.clk(clk), .srst(srst), .bus(i_apbi_bus_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_csr(cmd_csr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .busy(busy));
    apbi_far_end i_apbi_far_end (.clk(clk), .srst(srst), .bus(i_apbi_bus_if),
        .opcode_valid(opc_v), .opcode_byte(opc_b), .operand_strobe(op_s),
        .operand_word(op_w), .result_load(result_load),
        .result_word(result_word), .result_pending(pend),
        .polynomial_instruction_ready(polynomial_instruction_ready), .micro_pc(upc), .trap_strobe(trap_s),
        .port_ready(port_ready), .port_read_word(rd_word),
        .port_cmd_strobe(pc_s), .port_cmd_byte(pc_b),
        .port_write_strobe(pw_s), .port_write_word(pw_w));
    apbi_props i_apbi_props (.clk(clk), .srst(srst),
        .cpu_data_oe(i_apbi_bus_if.cpu_data_oe),
        .far_data_oe(i_apbi_bus_if.far_data_oe),
        .operand_valid_n(i_apbi_bus_if.operand_valid_n),
        .accel_sync(i_apbi_bus_if.accel_sync),
        .accel_select(i_apbi_bus_if.accel_select),
        .result_read_ready_n(i_apbi_bus_if.result_read_ready_n),
        .accel_trap_n(i_apbi_bus_if.accel_trap_n),
        .fetch_accel_micro_pc_n(i_apbi_bus_if.fetch_accel_micro_pc_n),
        .port_command_valid(i_apbi_bus_if.port_command_valid),
        .port_transfer_request_n(i_apbi_bus_if.port_transfer_request_n),
        .port_transfer_grant_n(i_apbi_bus_if.port_transfer_grant_n));

    ////////////////////////////////////////////////////////////////////////
    // capture of far-end strobes and wire values
    always @(posedge clk) begin
        if (opc_v === 1'b1) opc_q <= {24'h000000, opc_b};
        if (i_apbi_bus_if.decode_state_flag_n === 1'b0)
            ib_q <= {24'h000000, i_apbi_bus_if.instruction_byte_bus};
        if (op_s === 1'b1) op_q <= op_w;
        if (op_s === 1'b1) op_n <= op_n + 1;
        if (i_apbi_bus_if.operand_valid_n === 1'b0)
            bus_q <= i_apbi_bus_if.data_bus;
        if (pc_s === 1'b1) pc_q <= {24'h000000, pc_b};
        if (pw_s === 1'b1) wr_q <= pw_w;
        if (trap_s === 1'b1) trap_cnt <= trap_cnt + 1;
        if (rsp_valid === 1'b1) rsp_n <= rsp_n + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    task automatic push(input logic [3:0] op, input logic [17:0] csr,
                        input logic [31:0] d);
        int i;
        i = 0;
        while (cmd_ready !== 1'b1 && i < 100) begin
            cyc(1);
            i++;
        end
        cmd_op = op;
        cmd_csr = csr;
        cmd_data = d;
        cmd_valid = 1'b1;
        cyc(1);
        cmd_valid = 1'b0;
        cyc(1);
    endtask : push

    task automatic idle();
        int i;
        i = 0;
        do begin
            cyc(1);
            i++;
        end while (busy !== 1'b0 && i < 200);
        cyc(2);
        chk(32'h00000000, {31'h0, busy});
    endtask : idle

    task automatic port_go();
        int i;
        i = 0;
        port_ready = 1'b1;
        while (i_apbi_bus_if.port_transfer_grant_n !== 1'b0 && i < 100) begin
            cyc(1);
            i++;
        end
        chk(32'h0, 32'(i_apbi_bus_if.port_transfer_grant_n));
        port_ready = 1'b0;
        idle();
    endtask : port_go

    task automatic finish_test();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        cyc(6);
        srst = 1'b0;
        push(4'h0, 18'h00000, 32'h000000A5);
        idle();
        chk(32'h000000A5, opc_q);
        chk(32'h000000A5, ib_q);
        push(4'h1, 18'h00000, 32'hDEADBEEF);
        idle();
        chk(32'hDEADBEEF, op_q);
        chk(32'hDEADBEEF, bus_q);
        push(4'h4, 18'h00000, 32'h00000123);
        idle();
        chk(32'h00000123, upc);
        chk(32'h00000001, 32'(trap_cnt));
        push(4'h5, 18'h00000, 32'h00000000);
        idle();
        chk(32'h00000123, rsp_data);
        result_word = 32'hCAFE0001;
        result_load = 1'b1;
        cyc(1);
        result_load = 1'b0;
        chk(32'h00000001, 32'(pend));
        push(4'h3, 18'h00000, 32'h00000000);
        idle();
        chk(32'hCAFE0001, rsp_data);
        chk(32'h00000000, 32'(pend));
        n = op_n;
        push(4'h2, 18'h00000, 32'h0000F00D);
        cyc(10);
        chk(32'(n), 32'(op_n));
        polynomial_instruction_ready = 1'b1;
        idle();
        polynomial_instruction_ready = 1'b0;
        chk(32'h0000F00D, op_q);
        push(4'h6, 18'h16BFF, 32'h00000000);
        idle();
        chk(32'h0000005A, pc_q);
        push(4'h7, 18'h0F000, 32'h12345678);
        port_go();
        chk(32'h12345678, wr_q);
        chk(32'h0000003C, pc_q);
        rd_word = 32'h0BADF00D;
        push(4'h8, 18'h00000, 32'h00000000);
        port_go();
        chk(32'h0BADF00D, rsp_data);
        push(4'h3, 18'h00000, 32'h00000000);
        n = 0;
        while (cmd_ready === 1'b1 && n < 12) begin
            push(4'h1, 18'h00000, 32'h00000100 + 32'(n));
            n++;
        end
        chk(32'(FIFO_DEPTH), 32'(n));
        n = op_n;
        result_word = 32'hCAFE0002;
        result_load = 1'b1;
        cyc(1);
        result_load = 1'b0;
        idle();
        chk(32'hCAFE0002, rsp_data);
        chk(32'(n + 8), 32'(op_n));
        chk(32'h00000107, op_q);
        chk(32'h00000004, 32'(rsp_n));
        finish_test();
    end

    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
endmodule : accelerator_port_bus_interface_tb

`default_nettype wire
